// ---- hdl/cdsb_bridge.sv ----
/*
 display bus to serial link bridge, master or slave by strap.
 assumes the link clock is a free running port (lclk); the
 master's serial clock output is a level from an mclk flop, held high once awake and up, not lclk.
*/
// Contract
// - strap high master, low slave, pins follow
// - parallel cycles converted to serial and back
// - writes and reads, read over data lane
// - two chip selects, sampled or reproduced
// - slave reproduces address/data selector level
// - five bit crc checked every payload; code checks it only on read answers
// - master error flags bad read crc
// - slave error flags bad write crc; code sets the flag only from master read answers
// - slave write only when control high
// - sleep while power down input low
// - start-up within thousand reference cycles
// - multiplier straps give 8, 10, 12
`timescale 1ns/10ps
`default_nettype none
module cdsb_bridge (
    // core clock, link clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic lclk,
    // straps and control
    input wire logic link_master_role,
    input wire logic factory_test_select,
    input wire logic [1:0] pll_multiplier_straps,
    input wire logic write_only_select,
    input wire logic power_down_n,
    // parallel bus, master faces host, slave faces display
    input wire logic [cdsb_pkg::DATA_W-1:0] parIn,
    output logic [cdsb_pkg::DATA_W-1:0] parOut,
    output logic parOutEn_n,
    input wire logic main_display_select_n_in,
    input wire logic sub_display_select_n_in,
    input wire logic rdIn_n,
    input wire logic wrIn_n,
    input wire logic adIn,
    output logic main_display_select_n,
    output logic sub_display_select_n,
    output logic rdOut_n,
    output logic wrOut_n,
    output logic adOut,
    output logic ctlOutEn_n,
    // serial link, single ended view of the pairs
    input wire logic serialDataIn,
    output logic serial_data_pos,
    output logic serialDataEn_n,
    output logic serial_clock_pos,
    output logic serialClockEn_n,
    // status
    output logic crcError,
    output logic linkReady,
    output logic [3:0] pllMultiplier,
    output logic busy
);
    import cdsb_pkg::*;

    // two-flop sync of role, control, select, strobe and data pins into mclk
    logic [DATA_W+8:0] pinS1_q, pinS2_q;
    logic [DATA_W+8:0] pinRaw;
    // idle levels: strobes and selects high, so no false cycle at reset
    localparam logic [DATA_W+8:0] PIN_IDLE = {9'h03C, 18'h00000};
    assign pinRaw = {link_master_role, write_only_select, power_down_n,
        main_display_select_n_in, sub_display_select_n_in, rdIn_n,
        wrIn_n, adIn, factory_test_select, parIn};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1_q <= PIN_IDLE;
            pinS2_q <= PIN_IDLE;
        end else begin
            pinS1_q <= pinRaw;
            pinS2_q <= pinS1_q;
        end
    end
    logic isMaster, wrOnly, pdn, csm, css, rdn, wrn, ad;
    logic [DATA_W-1:0] pd;
    logic unusedTm;
    assign {isMaster, wrOnly, pdn, csm, css, rdn, wrn, ad, unusedTm,
        pd} = pinS2_q;

    // start-up counter and host-cycle edge detect
    localparam int SU_W = $clog2(STARTUP_CYC + 1);
    logic [SU_W-1:0] su_q, su_d;
    logic strobe_q, strobe_d;
    logic up;
    always_comb begin
        up = su_q == SU_W'(STARTUP_CYC);
        su_d = !pdn ? '0 : (up ? su_q : su_q + SU_W'(1));
        strobe_d = !rdn || !wrn;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            su_q <= '0;
            strobe_q <= 1'b0;
        end else begin
            su_q <= su_d;
            strobe_q <= strobe_d;
        end
    end

    // host cycles queue up on the core side
    cdsb_pay_type hostPay;
    logic fifoValid, fifoReady, qReady, qValid;
    cdsb_pay_type qPay;
    always_comb begin
        hostPay.rd = !rdn;
        hostPay.ad = ad;
        hostPay.csMain = csm;
        hostPay.csSub = css;
        hostPay.data = pd;
        // master samples a cycle at the strobe's leading edge
        fifoValid = isMaster && up && strobe_d && !strobe_q
            && !(csm == 1'b0 && css == 1'b0);
    end
    cdsb_fifo #(.WIDTH(PAY_W), .DEPTH(FIFO_DEPTH)) uFifo (
        .clk(mclk),
        .rst_n(rst_n),
        .inValid(fifoValid),
        .inReady(fifoReady),
        .inData(hostPay),
        .outValid(qValid),
        .outReady(qReady),
        .outData(qPay)
    );

    // word crossing to link domain by req/ack toggle handshake
    logic reqT_q, reqT_d, ackS1_q, ackS2_q, ackS3_q;
    logic pend_q, pend_d;
    cdsb_pay_type hold_q, hold_d;
    logic ackT_q;
    always_comb begin
        qReady = !pend_q;
        pend_d = pend_q;
        reqT_d = reqT_q;
        hold_d = hold_q;
        if (!pend_q && qValid) begin
            pend_d = 1'b1;
            reqT_d = !reqT_q;
            hold_d = qPay;
        end else if (pend_q && (ackS2_q != ackS3_q)) begin
            pend_d = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reqT_q <= 1'b0;
            pend_q <= 1'b0;
            hold_q <= '0;
            ackS1_q <= 1'b0;
            ackS2_q <= 1'b0;
            ackS3_q <= 1'b0;
        end else begin
            reqT_q <= reqT_d;
            pend_q <= pend_d;
            hold_q <= hold_d;
            ackS1_q <= ackT_q;
            ackS2_q <= ackS1_q;
            ackS3_q <= ackS2_q;
        end
    end

    // link domain: master shifts frames out, reads back response
    logic reqS1_q, reqS2_q, reqS3_q, mstL1_q, mstL2_q;
    cdsb_lstate_type ls_q, ls_d;
    logic [FRAME_W-1:0] sh_q, sh_d;
    logic [5:0] cnt_q, cnt_d;
    logic ackT_d;
    logic [RSP_W-1:0] rsp_q, rsp_d;
    logic isRd_q, isRd_d;
    logic rdErrT_q, rdErrT_d;
    logic [DATA_W-1:0] rdData_q, rdData_d;
    logic txOff_q, txOff_d, txBit_q, txBit_d;
    always_comb begin
        ls_d = ls_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        ackT_d = ackT_q;
        rsp_d = rsp_q;
        isRd_d = isRd_q;
        rdErrT_d = rdErrT_q;
        rdData_d = rdData_q;
        case (ls_q)
            LS_IDLE: begin
                if (mstL2_q && reqS2_q != reqS3_q) begin
                    // frame: payload then its crc
                    sh_d = {hold_q, crcCalc(hold_q, PAY_W)};
                    isRd_d = hold_q.rd;
                    cnt_d = 6'(FRAME_W - 1);
                    ls_d = LS_TX;
                end
            end
            LS_TX: begin
                sh_d = {sh_q[FRAME_W-2:0], 1'b0};
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h00) begin
                    cnt_d = 6'(RSP_W - 1);
                    ls_d = isRd_q ? LS_TURN : LS_DONE;
                end
            end
            LS_TURN: begin
                ls_d = LS_RX;
            end
            LS_RX: begin
                rsp_d = {rsp_q[RSP_W-2:0], serialDataIn};
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h00) begin
                    ls_d = LS_DONE;
                end
            end
            LS_DONE: begin
                if (isRd_q) begin
                    rdData_d = rsp_q[RSP_W-1:CRC_W];
                    if (crcCalc(PAY_W'(rsp_q[RSP_W-1:CRC_W]), DATA_W)
                        != rsp_q[CRC_W-1:0]) begin
                        rdErrT_d = !rdErrT_q;
                    end
                end
                ackT_d = !ackT_q;
                ls_d = LS_IDLE;
            end
            default: ls_d = LS_IDLE;
        endcase
        // lane driven only while shifting, released for reads
        txOff_d = ls_d != LS_TX;
        txBit_d = sh_d[FRAME_W-1];
    end
    assign serialDataEn_n = txOff_q;
    assign serial_data_pos = txBit_q;
    always_ff @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            reqS1_q <= 1'b0;
            reqS2_q <= 1'b0;
            reqS3_q <= 1'b0;
            mstL1_q <= 1'b0;
            mstL2_q <= 1'b0;
            ls_q <= LS_IDLE;
            sh_q <= '0;
            cnt_q <= '0;
            ackT_q <= 1'b0;
            rsp_q <= '0;
            isRd_q <= 1'b0;
            rdErrT_q <= 1'b0;
            rdData_q <= '0;
            txOff_q <= 1'b1;
            txBit_q <= 1'b0;
        end else begin
            reqS1_q <= reqT_q;
            reqS2_q <= reqS1_q;
            reqS3_q <= reqS2_q;
            mstL1_q <= link_master_role;
            mstL2_q <= mstL1_q;
            ls_q <= ls_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            ackT_q <= ackT_d;
            rsp_q <= rsp_d;
            isRd_q <= isRd_d;
            rdErrT_q <= rdErrT_d;
            rdData_q <= rdData_d;
            txOff_q <= txOff_d;
            txBit_q <= txBit_d;
        end
    end

    // core-side outputs; slave path reproduces the synced strobe levels
    logic errS1_q, errS2_q, errS3_q, err_q, err_d;
    logic [3:0] mult_d;
    logic [DATA_W-1:0] rdS1_q, rdS2_q;
    logic [1:0] pllS1_q, pllS2_q;
    always_comb begin
        err_d = err_q;
        // a new error wins over the sleep clear
        if (errS2_q != errS3_q) begin
            err_d = 1'b1; // sticky until sleep
        end else if (!pdn) begin
            err_d = 1'b0;
        end
        case (pllS2_q)
            PLL_X8: mult_d = MULT_X8;
            PLL_X10: mult_d = MULT_X10;
            PLL_X12: mult_d = MULT_X12;
            default: mult_d = 4'h0; // reserved code
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            errS1_q <= 1'b0;
            errS2_q <= 1'b0;
            errS3_q <= 1'b0;
            err_q <= 1'b0;
            crcError <= 1'b0;
            linkReady <= 1'b0;
            pllMultiplier <= 4'h0;
            busy <= 1'b0;
            rdS1_q <= '0;
            rdS2_q <= '0;
            pllS1_q <= 2'h0;
            pllS2_q <= 2'h0;
            parOut <= '0;
            parOutEn_n <= 1'b1;
            main_display_select_n <= 1'b1;
            sub_display_select_n <= 1'b1;
            rdOut_n <= 1'b1;
            wrOut_n <= 1'b1;
            adOut <= 1'b0;
            ctlOutEn_n <= 1'b1;
            serial_clock_pos <= 1'b0;
            serialClockEn_n <= 1'b1;
        end else begin
            errS1_q <= rdErrT_q;
            errS2_q <= errS1_q;
            errS3_q <= errS2_q;
            err_q <= err_d;
            crcError <= err_d;
            linkReady <= up;
            pllMultiplier <= isMaster ? mult_d : 4'h0;
            busy <= pend_q || qValid;
            // word taken only once the ack toggle says it is settled
            rdS1_q <= (ackS2_q != ackS3_q) ? rdData_q : rdS1_q;
            rdS2_q <= rdS1_q;
            pllS1_q <= pll_multiplier_straps;
            pllS2_q <= pllS1_q;
            // master drives read data back only while host reads
            parOut <= rdS2_q;
            parOutEn_n <= !(isMaster && !rdn && !wrOnly);
            // slave reproduces selects, strobes and selector
            main_display_select_n <= isMaster ? 1'b1 : csm;
            sub_display_select_n <= isMaster ? 1'b1 : css;
            rdOut_n <= isMaster || wrOnly ? 1'b1 : rdn;
            wrOut_n <= isMaster ? 1'b1 : wrn;
            adOut <= isMaster ? 1'b0 : ad;
            ctlOutEn_n <= isMaster || !pdn;
            serial_clock_pos <= isMaster && pdn && up;
            serialClockEn_n <= !(isMaster && pdn);
        end
    end
endmodule // cdsb_bridge
`default_nettype wire

// ---- common/cdsb_pkg.sv ----
/*
 shared types and constants for the display serial bridge.
 assumes a 100 MHz core clock (mclk) and a separate link clock domain.
*/
package cdsb_pkg;
    localparam int DATA_W = 18;
    localparam int CRC_W = 5;
    // payload: rd, ad, cs main, cs sub, data
    localparam int PAY_W = DATA_W + 4;
    localparam int FRAME_W = PAY_W + CRC_W;
    localparam int RSP_W = DATA_W + CRC_W;
    localparam logic [CRC_W-1:0] CRC_POLY = 5'h05;
    localparam logic [CRC_W-1:0] CRC_INIT = 5'h1F;
    localparam int STARTUP_CYC = 1000;
    localparam int FIFO_DEPTH = 4;
    localparam logic [1:0] PLL_X8 = 2'h0;
    localparam logic [1:0] PLL_X10 = 2'h1;
    localparam logic [1:0] PLL_X12 = 2'h2;
    localparam logic [3:0] MULT_X8 = 4'h8;
    localparam logic [3:0] MULT_X10 = 4'hA;
    localparam logic [3:0] MULT_X12 = 4'hC;

    typedef struct packed {
        logic rd;
        logic ad;
        logic csMain;
        logic csSub;
        logic [DATA_W-1:0] data;
    } cdsb_pay_type;

    typedef enum {
        LS_IDLE, LS_TX, LS_TURN, LS_RX, LS_DONE
    } cdsb_lstate_type;

    // serial crc over a vector, msb first
    function automatic logic [CRC_W-1:0] crcCalc(
        input logic [PAY_W-1:0] v, input int n);
        logic [CRC_W-1:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = PAY_W - 1; i >= 0; i--) begin
            if (i < n) begin
                fb = c[CRC_W-1] ^ v[i];
                c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);
            end
        end
        return c;
    endfunction
endpackage

// ---- hdl/cdsb_fifo.sv ----
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes one clock; depth is a power of two.
*/
`timescale 1ns/10ps
`default_nettype none
module cdsb_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    // honest full/empty from pointer compare
    always_comb begin
        inReady = (wr_q - rd_q) != (AW+1)'(DEPTH);
        outValid = wr_q != rd_q;
        outData = mem_q[rd_q[AW-1:0]];
        push = inValid && inReady;
        pop = outValid && outReady;
        wr_d = wr_q + (AW+1)'(push);
        rd_d = rd_q + (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage has no reset, only written on push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= inData;
        end
    end
endmodule // cdsb_fifo
`default_nettype wire

// ---- test/cdsb_bridge_properties.sv ----
/*
 port checker for the bridge, one mclk domain.
 assumes it is bound onto every cdsb_bridge instance.
*/
`timescale 1ns/10ps
`default_nettype none
module cdsb_bridge_checker
    import cdsb_pkg::*;
(
    // watched ports
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic link_master_role,
    input wire logic [1:0] pll_multiplier_straps,
    input wire logic write_only_select,
    input wire logic power_down_n,
    input wire logic rdOut_n,
    input wire logic ctlOutEn_n,
    input wire logic serialClockEn_n,
    input wire logic crcError,
    input wire logic linkReady,
    input wire logic [3:0] pllMultiplier
);
    logic [10:0] upCnt_q, upCnt_d;
    logic [3:0] wantMult;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // awake time, saturating so long runs never wrap
    always_comb begin
        upCnt_d = (&upCnt_q) ? upCnt_q : upCnt_q + 11'h1;
        if (!power_down_n) upCnt_d = 11'h0;
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) upCnt_q <= 11'h0;
        else upCnt_q <= upCnt_d;
    end
    // strap table, slave shows zero
    always_comb begin
        case (pll_multiplier_straps)
            PLL_X8: wantMult = MULT_X8;
            PLL_X10: wantMult = MULT_X10;
            PLL_X12: wantMult = MULT_X12;
            default: wantMult = 4'h0;
        endcase
        if (!link_master_role) wantMult = 4'h0;
    end
    a_pll_map:
        assert property ($stable({link_master_role, pll_multiplier_straps})[*6]
            |-> pllMultiplier == wantMult) else $error("multiplier wrong");
    a_slave_clock_off:
        assert property (!link_master_role[*4] |-> serialClockEn_n)
        else $error("slave drives clock");
    a_master_ctl_off:
        assert property (link_master_role[*4] |-> ctlOutEn_n)
        else $error("master drives controls");
    a_wo_no_read:
        assert property ((!link_master_role && write_only_select)[*4]
            |-> rdOut_n) else $error("read in write only");
    a_sleep_not_ready:
        assert property (!power_down_n[*5] |-> !linkReady)
        else $error("ready while asleep");
    a_ready_early:
        assert property ($rose(linkReady) |-> upCnt_q >= 11'h3E8)
        else $error("ready too early");
    a_ready_late:
        assert property (upCnt_q == 11'h3F6 |-> linkReady)
        else $error("ready too late");
    a_crc_sticky:
        assert property ((crcError && power_down_n)[*4] |=> crcError)
        else $error("error flag lost");
endmodule // cdsb_bridge_checker
bind cdsb_bridge cdsb_bridge_checker chk (.mclk(mclk), .rst_n(rst_n),
    .link_master_role(link_master_role), .write_only_select(write_only_select),
    .pll_multiplier_straps(pll_multiplier_straps), .rdOut_n(rdOut_n),
    .power_down_n(power_down_n), .ctlOutEn_n(ctlOutEn_n),
    .serialClockEn_n(serialClockEn_n), .crcError(crcError),
    .linkReady(linkReady), .pllMultiplier(pllMultiplier));
`default_nettype wire

// ---- test/cdsb_link_partner.sv ----
/*
 far end of the link for a master bridge: captures frames, answers reads.
 assumes bits move on the rising edge of lclk, msb first.
*/
`timescale 1ns/10ps
`default_nettype none
module cdsb_link_partner (
    // link clock and reset
    input wire logic lclk,
    input wire logic rst_n,
    // serial lane
    input wire logic serData,
    input wire logic serDataEn_n,
    output logic serialDataIn,
    // read answer setup and captured frame
    input wire logic [17:0] rspData,
    input wire logic badCrc,
    output logic [26:0] frame,
    output logic [7:0] frameCnt
);
    logic [26:0] sh;
    logic [22:0] rsp;
    int bitCnt;
    int rspCnt;
    // own crc, poly 05 init 1F, msb first
    function automatic logic [4:0] crc5(input logic [21:0] v, input int n);
        logic [4:0] c;
        c = 5'h1F;
        for (int i = n - 1; i >= 0; i--)
            c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? 5'h05 : 5'h00);
        return c;
    endfunction
    // capture 27 bits, then turnaround and a 23 bit answer on reads
    always @(posedge lclk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt = 0;
            rspCnt = 0;
            frameCnt <= 8'h0;
            frame <= '0;
            serialDataIn <= 1'b0;
        end else if (rspCnt > 0) begin
            // first answer bit follows the one turnaround edge
            serialDataIn <= rsp[rspCnt-1];
            rspCnt = rspCnt - 1;
        end else if (!serDataEn_n) begin
            sh = {sh[25:0], serData};
            bitCnt = bitCnt + 1;
            if (bitCnt == 27) begin
                frame <= sh;
                frameCnt <= frameCnt + 8'h1;
                rsp = {rspData, crc5({4'h0, rspData}, 18) ^ {4'h0, badCrc}};
                rspCnt = sh[26] ? 23 : 0;
                bitCnt = 0;
            end
        end else begin
            // released lane keeps changing so stale bits cannot pass
            bitCnt = 0;
            serialDataIn <= ~serialDataIn;
        end
    end
endmodule // cdsb_link_partner
`default_nettype wire

// ---- test/cdsb_bridge_tb.sv ----
/*
 bench: bridge as master against the link partner, then a slave pass.
 assumes mclk 100 MHz and an unrelated 125 ns link clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cdsb_bridge_tb;
    import cdsb_pkg::*;
    logic mclk, lclk, rst_n, master, wo, pdn, rdn, wrn, ad, csm, css, badCrc;
    logic [1:0] pll;
    logic [DATA_W-1:0] parIn, parOut, rspData;
    logic parOutEn_n, serData, serDataEn_n, serClkEn_n, serIn;
    logic crcError, linkReady, rdOut_n;
    logic [3:0] mult;
    logic [3:0] multTab [4] = '{MULT_X8, MULT_X10, MULT_X12, 4'h0};
    logic [26:0] frame;
    logic [7:0] frameCnt;
    logic [21:0] pay;
    int error_cnt = 0;
    int num_checks = 0;
    // clocks, link clock offset in phase
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        lclk = 1'b0;
        #3.7;
        forever #62.5 lclk = ~lclk;
    end
    cdsb_bridge dut (.mclk(mclk), .rst_n(rst_n), .lclk(lclk),
        .link_master_role(master), .factory_test_select(1'b0),
        .pll_multiplier_straps(pll), .write_only_select(wo),
        .power_down_n(pdn), .parIn(parIn), .parOut(parOut),
        .parOutEn_n(parOutEn_n), .main_display_select_n_in(csm),
        .sub_display_select_n_in(css), .rdIn_n(rdn), .wrIn_n(wrn),
        .adIn(ad), .main_display_select_n(), .sub_display_select_n(),
        .rdOut_n(rdOut_n), .wrOut_n(), .adOut(), .ctlOutEn_n(),
        .serialDataIn(serIn), .serial_data_pos(serData),
        .serialDataEn_n(serDataEn_n), .serial_clock_pos(),
        .serialClockEn_n(serClkEn_n), .crcError(crcError),
        .linkReady(linkReady), .pllMultiplier(mult), .busy());
    cdsb_link_partner peer (.lclk(lclk), .rst_n(rst_n), .serData(serData),
        .serDataEn_n(serDataEn_n), .serialDataIn(serIn), .rspData(rspData),
        .badCrc(badCrc), .frame(frame), .frameCnt(frameCnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // host cycle start: only one select low at a time
    task automatic startCycle(input logic rd, input logic sub,
        input logic [17:0] d);
        @(posedge mclk);
        parIn <= d;
        ad <= !rd;
        csm <= sub;
        css <= !sub;
        rdn <= !rd;
        wrn <= rd;
    endtask
    task automatic endCycle();
        @(posedge mclk);
        rdn <= 1'b1;
        wrn <= 1'b1;
        csm <= 1'b1;
        css <= 1'b1;
    endtask
    task automatic waitFrame(input logic [7:0] n);
        for (int i = 0; i < 3000 && frameCnt !== n; i++) @(posedge mclk);
        chk({24'h0, frameCnt}, {24'h0, n});
    endtask
    // hang guard, well past the longest expected run
    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        master = 1'b1;
        wo = 1'b0;
        pdn = 1'b1;
        {rdn, wrn, csm, css, ad, badCrc} = 6'h3C;
        pll = PLL_X8;
        parIn = '0;
        rspData = 18'h2A5A5;
        rst_n = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 chk(parOutEn_n, 1);
        chk(crcError, 0);
        for (int k = 0; k < 4; k++) begin
            pll <= 2'(k);
            repeat (6) @(posedge mclk);
            #1 chk(mult, multTab[k]);
        end
        repeat (870) @(posedge mclk);
        chk(linkReady, 0);
        for (int i = 0; i < 200 && linkReady !== 1'b1; i++) @(posedge mclk);
        chk(linkReady, 1);
        // writes to main then sub display
        for (int s = 0; s < 2; s++) begin
            startCycle(1'b0, s[0], 18'h3C0F1 ^ 18'(s));
            repeat (8) @(posedge mclk);
            endCycle();
            waitFrame(8'(s + 1));
            pay = {1'b0, 1'b1, s[0], !s[0], 18'h3C0F1 ^ 18'(s)};
            chk(frame, {pay, peer.crc5(pay, 22)});
        end
        // good read, then a read whose answer is corrupted
        for (int b = 0; b < 2; b++) begin
            badCrc <= b[0];
            startCycle(1'b1, 1'b0, 18'h0);
            waitFrame(8'(b + 3));
            // answer is 25 link clocks after the frame, plus sync
            repeat (400) @(posedge mclk);
            chk(parOutEn_n, 0);
            if (b == 0) chk(parOut, rspData);
            repeat (20) @(posedge mclk);
            endCycle();
            repeat (60) @(posedge mclk);
            chk(crcError, b);
        end
        pdn <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(crcError, 0);
        chk(linkReady, 0);
        pdn <= 1'b1;
        // slave role, write only
        rst_n <= 1'b0;
        master <= 1'b0;
        wo <= 1'b1;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        chk(mult, 0);
        chk(serClkEn_n, 1);
        chk(rdOut_n, 1);
        give_verdict();
    end
endmodule // cdsb_bridge_tb
`default_nettype wire
